// [srb_special_register_bank.sv]
// special register bank: direct-address register map with per-source reset values
`timescale 1ns/10ps
module srb_special_register_bank
  import srb_pkg::*;
#(
  parameter logic [7:0] FACTORY_TUNE = 8'h20 // arbitrary default, factory value
)(
  input wire logic core_clk,
  input wire logic resetn,
  input wire srb_access_t access,
  input wire srb_reset_cause_t cause,
  input wire logic [7:0] flashStatus,
  output logic [7:0] rdata,
  output logic rdValid,
  output logic [7:0] flashCommand,
  output logic flashCommandStrobe,
  output logic baudWriteHazard,
  output logic machineCycleEnable,
  output logic peripheralClockEnable,
  output logic [7:0] port0ModeA,
  output logic [7:0] port1ModeA,
  output logic [7:0] port3ModeA,
  output logic [7:0] watchdogControl,
  output logic [7:0] rcTune,
  output logic [7:0] baudControl
);
  // plain storage indexed by the low seven address bits
  logic [7:0] regs_q [128];
  logic [6:0] idx;
  logic direct;
  logic wrHit;
  logic [7:0] wval;
  logic [7:0] rval;
  logic [7:0] cur;
  logic powerOnReset;
  logic [7:0] causeValue;
  logic phase_q;

  // only direct accesses into the upper half reach the bank
  assign direct = !access.indirect && (access.addr >= ADDR_SPACE_BASE);
  assign idx = access.addr[6:0];
  assign cur = regs_q[idx];
  assign wrHit = access.wr && direct;
  assign powerOnReset = cause.powerOn;

  // bit accesses: wdata[2:0] selects the bit, wdata[3] holds its value
  function automatic logic [7:0] merge(input logic [7:0] old, input logic bitOp,
                                       input logic [7:0] wd);
    logic [7:0] r;
    r = wd;
    if (bitOp) begin
      r = old;
      r[wd[2:0]] = wd[3];
    end
    return r;
  endfunction

  // is this address bit addressable (low nibble 0 or 8)
  function automatic logic bitAddressable(input logic [7:0] a);
    return a[2:0] == 3'h0;
  endfunction

  assign wval = merge(cur, access.bitOp && bitAddressable(access.addr), access.wdata);

  // read value with reserved and fixed bits forced
  function automatic logic [7:0] readMask(input logic [7:0] a, input logic [7:0] v);
    logic [7:0] m;
    m = v;
    if (a == ADDR_AUX_FUNCTION) begin
      m = v & MASK_AUX_FUNCTION;
    end else if (a == ADDR_BAUD_GEN_CONTROL) begin
      m = v & MASK_BAUD_GEN_CONTROL;
    end else if (a == ADDR_COMPARATOR_ONE || a == ADDR_COMPARATOR_TWO) begin
      m = v & MASK_COMPARATOR;
    end else if (a == ADDR_KEYPAD_CONTROL) begin
      m = v & MASK_KEYPAD_CONTROL;
    end else if (a == ADDR_TIMER_AUX_MODE) begin
      m = v & MASK_TIMER_AUX_MODE;
    end else if (a == ADDR_PORT1_MODE_A || a == ADDR_PORT1_MODE_B) begin
      m = v & MASK_PORT1_MODE;
    end else if (a == ADDR_PORT3_MODE_A || a == ADDR_PORT3_MODE_B) begin
      m = v & MASK_PORT3_MODE;
    end else if (a == ADDR_IRQ_ENABLE_B || a == ADDR_IRQ_PRIORITY_B ||
                 a == ADDR_IRQ_PRIORITY_B_HIGH) begin
      m = v & MASK_IRQ_B;
    end else if (a == ADDR_IRQ_PRIORITY_A || a == ADDR_IRQ_PRIORITY_A_HIGH) begin
      m = v & MASK_IRQ_PRIORITY_A;
    end else if (a == ADDR_POWER_CONTROL_EXT) begin
      m = v & MASK_POWER_CONTROL_EXT;
    end else if (a == ADDR_I2C_CONTROL) begin
      m = v & MASK_I2C_CONTROL;
    end else if (a == ADDR_I2C_STATUS) begin
      m = v & RST_I2C_STATUS; // low three bits fixed zero
    end else if (a == ADDR_RTC_CONTROL) begin
      m = v & MASK_RTC_CONTROL;
    end else if (a == ADDR_WATCHDOG_CONTROL) begin
      m = v & MASK_WATCHDOG_CONTROL;
    end else if (a == ADDR_RESET_CAUSE) begin
      m = v & MASK_RESET_CAUSE;
    end else if (a == ADDR_RC_TUNE_VALUE) begin
      m = v & MASK_RC_TUNE;
    end
    return m;
  endfunction

  // reset cause value built from the sources of the latest reset
  always_comb begin
    causeValue = RST_ZERO;
    causeValue[BIT_POWER_ON] = cause.powerOn;
    causeValue[BIT_BROWNOUT] = cause.brownout | cause.powerOn;
    causeValue[BIT_CAUSE_WATCHDOG] = cause.watchdog;
    causeValue[BIT_CAUSE_SOFTWARE] = cause.software;
    causeValue[BIT_CAUSE_EXTERNAL] = cause.external;
    causeValue[BIT_CAUSE_BREAK] = cause.breakDetect;
  end

  // read path: flash location returns live status, others storage
  always_comb begin
    rval = RST_ZERO;
    if (!direct) begin
      rval = RST_ZERO; // outside the bank reads zero
    end else if (access.addr == ADDR_FLASH_CONTROL_STATUS) begin
      rval = (regs_q[idx] | flashStatus) & MASK_FLASH_STATUS;
      rval = rval | RST_FLASH_STATUS;
    end else begin
      rval = readMask(access.addr, cur);
    end
  end

  // read data registered, answered one cycle after the request
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rdata <= RST_ZERO;
      rdValid <= 1'b0;
    end else begin
      rdValid <= access.rd && direct;
      if (access.rd && direct) begin
        rdata <= rval;
      end
    end
  end

  // register storage has no asynchronous reset; reset holds loadReset_q, and the
  // per-source reset values are loaded at every edge while reset is held and at the first edge
  // after release, through the cause inputs, which hold while the reset is pending
  logic loadReset_q;
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      loadReset_q <= 1'b1;
    end else begin
      loadReset_q <= 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (loadReset_q) begin
      for (int i = 0; i < 128; i++) begin
        // power-on-only registers keep their contents on other resets
        if (!(8'(i + 128) inside {ADDR_RTC_CONTROL, ADDR_RTC_COUNT_HIGH, ADDR_RTC_COUNT_LOW,
                             ADDR_RC_TUNE_VALUE, ADDR_WATCHDOG_CONTROL}) || powerOnReset) begin
          regs_q[i] <= RST_ZERO;
        end
      end
      regs_q[ADDR_STACK_POINTER[6:0]] <= RST_STACK_POINTER;
      regs_q[ADDR_PORT0_MODE_A[6:0]] <= RST_PORT0_MODE_A;
      regs_q[ADDR_PORT1_MODE_A[6:0]] <= RST_PORT1_MODE_A;
      regs_q[ADDR_PORT3_MODE_A[6:0]] <= RST_PORT3_MODE_A;
      regs_q[ADDR_KEYPAD_PATTERN[6:0]] <= RST_KEYPAD_PATTERN;
      regs_q[ADDR_WATCHDOG_LOAD[6:0]] <= RST_WATCHDOG_LOAD;
      regs_q[ADDR_I2C_STATUS[6:0]] <= RST_I2C_STATUS;
      regs_q[ADDR_RESET_CAUSE[6:0]] <= causeValue;
      if (powerOnReset) begin
        regs_q[ADDR_RTC_CONTROL[6:0]] <= RST_RTC_CONTROL;
        regs_q[ADDR_RC_TUNE_VALUE[6:0]] <= FACTORY_TUNE & MASK_RC_TUNE;
        regs_q[ADDR_WATCHDOG_CONTROL[6:0]] <= RST_WATCHDOG_CONTROL;
      end else if (cause.watchdog) begin
        // other resets keep watchdog control, only the timeout flag moves
        regs_q[ADDR_WATCHDOG_CONTROL[6:0]][BIT_WATCHDOG_TIMEOUT] <= 1'b1;
      end
    end else if (wrHit && access.addr != ADDR_I2C_STATUS) begin
      if (access.addr == ADDR_FLASH_CONTROL_STATUS) begin
        // writes here are commands, the status byte is not overwritten
        regs_q[idx] <= regs_q[idx];
      end else begin
        regs_q[idx] <= wval;
      end
    end
  end

  // flash command strobe: one cycle pulse with registered command byte
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      flashCommand <= RST_ZERO;
      flashCommandStrobe <= 1'b0;
    end else begin
      flashCommandStrobe <= wrHit && access.addr == ADDR_FLASH_CONTROL_STATUS;
      if (wrHit && access.addr == ADDR_FLASH_CONTROL_STATUS) begin
        flashCommand <= access.wdata;
      end
    end
  end

  // flags a divisor write made while the generator runs; result is undefined
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      baudWriteHazard <= 1'b0;
    end else begin
      baudWriteHazard <= wrHit &&
        (access.addr == ADDR_BAUD_RATE_LOW || access.addr == ADDR_BAUD_RATE_HIGH) &&
        regs_q[ADDR_BAUD_GEN_CONTROL[6:0]][BIT_BAUD_GEN_ENABLE];
    end
  end

  // two cpu clocks per machine cycle; peripheral clock is the same half rate
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      phase_q <= 1'b0;
    end else begin
      phase_q <= !phase_q;
    end
  end
  assign machineCycleEnable = phase_q;
  assign peripheralClockEnable = phase_q;

  // register contents steering the device
  assign port0ModeA = regs_q[ADDR_PORT0_MODE_A[6:0]];
  assign port1ModeA = regs_q[ADDR_PORT1_MODE_A[6:0]] & MASK_PORT1_MODE;
  assign port3ModeA = regs_q[ADDR_PORT3_MODE_A[6:0]] & MASK_PORT3_MODE;
  assign watchdogControl = regs_q[ADDR_WATCHDOG_CONTROL[6:0]] & MASK_WATCHDOG_CONTROL;
  assign rcTune = regs_q[ADDR_RC_TUNE_VALUE[6:0]] & MASK_RC_TUNE;
  assign baudControl = regs_q[ADDR_BAUD_GEN_CONTROL[6:0]] & MASK_BAUD_GEN_CONTROL;

  // assertions; all are off while reset is held
  // fixed-zero aux bit, checked on the read data the cpu really sees
  fixed_zero_a: assert property (@(posedge core_clk) disable iff (!resetn)
    (access.rd && direct && access.addr == ADDR_AUX_FUNCTION)
    |=> !rdata[BIT_FIXED_ZERO_AUX])
    else $error("fixed zero bit read as one");

  // every direct read is answered on the next edge
  read_latency_a: assert property (@(posedge core_clk) disable iff (!resetn)
    (access.rd && direct) |=> rdValid)
    else $error("read not answered next cycle");

  // indirect reads belong to data memory, the bank stays silent
  indirect_read_a: assert property (@(posedge core_clk) disable iff (!resetn)
    (access.rd && access.indirect) |=> !rdValid)
    else $error("indirect access answered by bank");

  // a write to the flash location becomes a command pulse
  flash_cmd_a: assert property (@(posedge core_clk) disable iff (!resetn)
    (wrHit && access.addr == ADDR_FLASH_CONTROL_STATUS)
    |=> flashCommandStrobe && flashCommand == $past(access.wdata))
    else $error("flash command not delivered");

  // fixed-one status bits survive whatever the flash reports
  flash_read_a: assert property (@(posedge core_clk) disable iff (!resetn)
    (access.rd && direct && access.addr == ADDR_FLASH_CONTROL_STATUS)
    |=> (rdata & RST_FLASH_STATUS) == RST_FLASH_STATUS)
    else $error("flash status fixed ones missing");

  // power-on leaves the watchdog running with the longest prescale
  wd_power_on_a: assert property (@(posedge core_clk) disable iff (!resetn)
    (loadReset_q && powerOnReset) |=> watchdogControl == RST_WATCHDOG_CONTROL)
    else $error("watchdog control wrong after power on");

  // software learns of a watchdog reset through the timeout flag
  wd_timeout_a: assert property (@(posedge core_clk) disable iff (!resetn)
    (loadReset_q && !powerOnReset && cause.watchdog)
    |=> watchdogControl[BIT_WATCHDOG_TIMEOUT])
    else $error("timeout flag not set by watchdog reset");

  // a warm reset must not retune the oscillator under the cpu
  tune_keep_a: assert property (@(posedge core_clk) disable iff (!resetn)
    (loadReset_q && !powerOnReset) |=> $stable(rcTune))
    else $error("tune value changed by non power-on reset");

  // clean power-up shows only the power-on and brownout flags
  cause_power_a: assert property (@(posedge core_clk) disable iff (!resetn)
    (loadReset_q && powerOnReset && !cause.watchdog && !cause.software &&
     !cause.external && !cause.breakDetect)
    |=> regs_q[ADDR_RESET_CAUSE[6:0]] == RST_RESET_CAUSE_POWER)
    else $error("reset cause wrong after power up");

  // ports come out of every reset as inputs, nothing driven
  port_mode_a: assert property (@(posedge core_clk) disable iff (!resetn)
    loadReset_q |=> port0ModeA == RST_PORT0_MODE_A && port1ModeA == RST_PORT1_MODE_A)
    else $error("port mode not input-only after reset");

  // peripheral enable high one cpu clock in two
  half_rate_a: assert property (@(posedge core_clk) disable iff (!resetn)
    peripheralClockEnable |=> !peripheralClockEnable ##1 peripheralClockEnable)
    else $error("peripheral enable not at half rate");

  // low divisor byte write while the generator runs must be flagged
  baud_hazard_a: assert property (@(posedge core_clk) disable iff (!resetn)
    (wrHit && access.addr == ADDR_BAUD_RATE_LOW && baudControl[BIT_BAUD_GEN_ENABLE])
    |=> baudWriteHazard)
    else $error("divisor write while enabled not flagged");

  // power-on loads the rtc block to its reset values
  rtc_power_on_a: assert property (@(posedge core_clk) disable iff (!resetn)
    (loadReset_q && powerOnReset)
    |=> regs_q[ADDR_RTC_CONTROL[6:0]] == RST_RTC_CONTROL &&
        regs_q[ADDR_RTC_COUNT_HIGH[6:0]] == RST_ZERO &&
        regs_q[ADDR_RTC_COUNT_LOW[6:0]] == RST_ZERO)
    else $error("rtc registers wrong after power on");

  // warm resets must not disturb a running rtc, it keeps time across them
  rtc_keep_a: assert property (@(posedge core_clk) disable iff (!resetn)
    (loadReset_q && !powerOnReset)
    |=> $stable(regs_q[ADDR_RTC_CONTROL[6:0]]) &&
        $stable(regs_q[ADDR_RTC_COUNT_HIGH[6:0]]) &&
        $stable(regs_q[ADDR_RTC_COUNT_LOW[6:0]]))
    else $error("rtc registers changed by warm reset");

  // tune value comes from the factory parameter on power-on
  tune_power_on_a: assert property (@(posedge core_clk) disable iff (!resetn)
    (loadReset_q && powerOnReset) |=> rcTune == (FACTORY_TUNE & MASK_RC_TUNE))
    else $error("tune value not loaded on power on");

  // resets other than watchdog and power-on leave watchdog control alone
  wd_keep_a: assert property (@(posedge core_clk) disable iff (!resetn)
    (loadReset_q && !powerOnReset && !cause.watchdog)
    |=> $stable(watchdogControl))
    else $error("watchdog control changed by other reset");

  // a watchdog reset is recorded in the cause register
  cause_watchdog_a: assert property (@(posedge core_clk) disable iff (!resetn)
    (loadReset_q && cause.watchdog)
    |=> regs_q[ADDR_RESET_CAUSE[6:0]][BIT_CAUSE_WATCHDOG])
    else $error("watchdog reset not recorded");

  // port 3 also comes out of reset input-only
  port3_mode_a: assert property (@(posedge core_clk) disable iff (!resetn)
    loadReset_q |=> port3ModeA == RST_PORT3_MODE_A)
    else $error("port 3 mode not input-only after reset");

  // machine cycle enable never high two cpu clocks in a row
  machine_cycle_a: assert property (@(posedge core_clk) disable iff (!resetn)
    machineCycleEnable |=> !machineCycleEnable)
    else $error("machine cycle enable held high");

  // status register is read-only, a write leaves it untouched
  status_readonly_a: assert property (@(posedge core_clk) disable iff (!resetn)
    (wrHit && !loadReset_q && access.addr == ADDR_I2C_STATUS)
    |=> $stable(regs_q[ADDR_I2C_STATUS[6:0]]))
    else $error("read-only status overwritten");

  // single-bit write sets the addressed bit to the given value
  bit_write_a: assert property (@(posedge core_clk) disable iff (!resetn)
    (wrHit && !loadReset_q && access.bitOp && access.addr == ADDR_TIMER_RUN_FLAGS)
    |=> regs_q[ADDR_TIMER_RUN_FLAGS[6:0]][$past(access.wdata[2:0])] ==
        $past(access.wdata[3]))
    else $error("single-bit write lost");
endmodule

// [srb_pkg.sv]
// package: register map, reset values and record types for the special register bank
package srb_pkg;
  // register offsets in the direct address space
  localparam logic [7:0] ADDR_PORT0_PINS = 8'h80;
  localparam logic [7:0] ADDR_STACK_POINTER = 8'h81;
  localparam logic [7:0] ADDR_PORT0_MODE_A = 8'h84;
  localparam logic [7:0] ADDR_PORT0_MODE_B = 8'h85;
  localparam logic [7:0] ADDR_KEYPAD_MASK = 8'h86;
  localparam logic [7:0] ADDR_POWER_CONTROL = 8'h87;
  localparam logic [7:0] ADDR_TIMER_RUN_FLAGS = 8'h88;
  localparam logic [7:0] ADDR_TIMER_MODE = 8'h89;
  localparam logic [7:0] ADDR_TIMER_AUX_MODE = 8'h8f;
  localparam logic [7:0] ADDR_PORT1_PINS = 8'h90;
  localparam logic [7:0] ADDR_PORT1_MODE_A = 8'h91;
  localparam logic [7:0] ADDR_PORT1_MODE_B = 8'h92;
  localparam logic [7:0] ADDR_KEYPAD_PATTERN = 8'h93;
  localparam logic [7:0] ADDR_KEYPAD_CONTROL = 8'h94;
  localparam logic [7:0] ADDR_CLOCK_DIVIDER = 8'h95;
  localparam logic [7:0] ADDR_RC_TUNE_VALUE = 8'h96;
  localparam logic [7:0] ADDR_SERIAL_CONTROL = 8'h98;
  localparam logic [7:0] ADDR_AUX_FUNCTION = 8'ha2;
  localparam logic [7:0] ADDR_WATCHDOG_CONTROL = 8'ha7;
  localparam logic [7:0] ADDR_IRQ_ENABLE_A = 8'ha8;
  localparam logic [7:0] ADDR_COMPARATOR_ONE = 8'hac;
  localparam logic [7:0] ADDR_COMPARATOR_TWO = 8'had;
  localparam logic [7:0] ADDR_PORT3_PINS = 8'hb0;
  localparam logic [7:0] ADDR_PORT3_MODE_A = 8'hb1;
  localparam logic [7:0] ADDR_PORT3_MODE_B = 8'hb2;
  localparam logic [7:0] ADDR_POWER_CONTROL_EXT = 8'hb5;
  localparam logic [7:0] ADDR_IRQ_PRIORITY_A_HIGH = 8'hb7;
  localparam logic [7:0] ADDR_IRQ_PRIORITY_A = 8'hb8;
  localparam logic [7:0] ADDR_SERIAL_EXT_STATUS = 8'hba;
  localparam logic [7:0] ADDR_BAUD_GEN_CONTROL = 8'hbd;
  localparam logic [7:0] ADDR_BAUD_RATE_LOW = 8'hbe;
  localparam logic [7:0] ADDR_BAUD_RATE_HIGH = 8'hbf;
  localparam logic [7:0] ADDR_WATCHDOG_LOAD = 8'hc1;
  localparam logic [7:0] ADDR_PROGRAM_STATUS_WORD = 8'hd0;
  localparam logic [7:0] ADDR_RTC_CONTROL = 8'hd1;
  localparam logic [7:0] ADDR_RTC_COUNT_HIGH = 8'hd2;
  localparam logic [7:0] ADDR_RTC_COUNT_LOW = 8'hd3;
  localparam logic [7:0] ADDR_I2C_CONTROL = 8'hd8;
  localparam logic [7:0] ADDR_I2C_STATUS = 8'hd9;
  localparam logic [7:0] ADDR_I2C_OWN_ADDRESS = 8'hdb;
  localparam logic [7:0] ADDR_RESET_CAUSE = 8'hdf;
  localparam logic [7:0] ADDR_FLASH_CONTROL_STATUS = 8'he4;
  localparam logic [7:0] ADDR_FLASH_DATA = 8'he5;
  localparam logic [7:0] ADDR_FLASH_ADDR_LOW = 8'he6;
  localparam logic [7:0] ADDR_FLASH_ADDR_HIGH = 8'he7;
  localparam logic [7:0] ADDR_IRQ_ENABLE_B = 8'he8;
  localparam logic [7:0] ADDR_IRQ_PRIORITY_B_HIGH = 8'hf7;
  localparam logic [7:0] ADDR_IRQ_PRIORITY_B = 8'hf8;
  // lowest direct address that reaches the register space
  localparam logic [7:0] ADDR_SPACE_BASE = 8'h80;
  // reset values that differ from zero, and the zero default
  localparam logic [7:0] RST_STACK_POINTER = 8'h07;
  localparam logic [7:0] RST_PORT0_MODE_A = 8'hff;
  localparam logic [7:0] RST_PORT1_MODE_A = 8'hd3;
  localparam logic [7:0] RST_PORT3_MODE_A = 8'h03;
  localparam logic [7:0] RST_KEYPAD_PATTERN = 8'hff;
  localparam logic [7:0] RST_WATCHDOG_LOAD = 8'hff;
  localparam logic [7:0] RST_RTC_CONTROL = 8'h60;
  localparam logic [7:0] RST_I2C_STATUS = 8'hf8;
  localparam logic [7:0] RST_FLASH_STATUS = 8'h70;
  localparam logic [7:0] RST_WATCHDOG_CONTROL = 8'he5;
  localparam logic [7:0] RST_RESET_CAUSE_POWER = 8'h30;
  localparam logic [7:0] RST_ZERO = 8'h00;
  // read masks of writable bits (reserved and fixed bits read back as the fixed value)
  localparam logic [7:0] MASK_AUX_FUNCTION = 8'hf9;
  localparam logic [7:0] MASK_BAUD_GEN_CONTROL = 8'h03;
  localparam logic [7:0] MASK_COMPARATOR = 8'h3f;
  localparam logic [7:0] MASK_KEYPAD_CONTROL = 8'h03;
  localparam logic [7:0] MASK_TIMER_AUX_MODE = 8'h11;
  localparam logic [7:0] MASK_PORT1_MODE = 8'hdb;
  localparam logic [7:0] MASK_PORT3_MODE = 8'h03;
  localparam logic [7:0] MASK_IRQ_B = 8'h47;
  localparam logic [7:0] MASK_IRQ_PRIORITY_A = 8'h7f;
  localparam logic [7:0] MASK_POWER_CONTROL_EXT = 8'haa;
  localparam logic [7:0] MASK_I2C_CONTROL = 8'h7d;
  localparam logic [7:0] MASK_RTC_CONTROL = 8'he3;
  localparam logic [7:0] MASK_WATCHDOG_CONTROL = 8'he7;
  localparam logic [7:0] MASK_RESET_CAUSE = 8'h3f;
  localparam logic [7:0] MASK_FLASH_STATUS = 8'h8f;
  localparam logic [7:0] MASK_RC_TUNE = 8'h7f;
  // field positions
  localparam int BIT_BAUD_GEN_ENABLE = 0;
  localparam int BIT_WATCHDOG_TIMEOUT = 1;
  localparam int BIT_BROWNOUT = 5;
  localparam int BIT_POWER_ON = 4;
  localparam int BIT_CAUSE_BREAK = 3;
  localparam int BIT_CAUSE_WATCHDOG = 2;
  localparam int BIT_CAUSE_SOFTWARE = 1;
  localparam int BIT_CAUSE_EXTERNAL = 0;
  localparam int BIT_FIXED_ZERO_AUX = 2;
  // two cpu clocks per machine cycle
  localparam int CLOCKS_PER_MACHINE_CYCLE = 2;

  // one cpu access to the register space
  typedef struct packed {
    logic rd;
    logic wr;
    logic bitOp;
    logic indirect;
    logic [7:0] addr;
    logic [7:0] wdata;
  } srb_access_t;

  // reset sources seen in the latest reset
  typedef struct packed {
    logic powerOn;
    logic brownout;
    logic watchdog;
    logic software;
    logic external;
    logic breakDetect;
  } srb_reset_cause_t;
endpackage

// [tb_special_register_map_resets.sv]
// testbench: register map, reset values and access rules of the special register bank
`timescale 1ns/10ps
module tb_special_register_map_resets;
  import srb_pkg::*;
  localparam logic [7:0] TUNE = 8'h2a; // factory tune used in this run, arbitrary
  logic core_clk; // 100 ns cpu clock
  logic resetn; // async reset, active low
  srb_access_t access; // one cpu access
  srb_reset_cause_t cause; // sources of the latest reset
  logic [7:0] flashStatus; // live flash status bits
  logic [7:0] rdata;
  logic rdValid;
  logic [7:0] flashCommand;
  logic flashCommandStrobe;
  logic baudWriteHazard;
  logic machineCycleEnable;
  logic peripheralClockEnable;
  logic [7:0] port0ModeA;
  logic [7:0] port1ModeA;
  logic [7:0] port3ModeA;
  logic [7:0] watchdogControl;
  logic [7:0] rcTune;
  logic [7:0] baudControl;
  logic lastStrobe; // strobe seen right after a write
  logic lastHazard; // hazard seen right after a write
  logic pm; // previous machine cycle enable
  logic pp; // previous peripheral enable
  int fails;
  int checksDone;
  // power-on reset image: address and expected read
  logic [7:0] porAddr [17] = '{8'h84, 8'h85, 8'h91, 8'h92, 8'hb1, 8'hb2, 8'h81, 8'hd1,
    8'hd2, 8'hd3, 8'hdf, 8'ha7, 8'h96, 8'he4, 8'hd9, 8'h93, 8'hc1};
  logic [7:0] porVal [17] = '{8'hff, 8'h00, 8'hd3, 8'h00, 8'h03, 8'h00, 8'h07, 8'h60,
    8'h00, 8'h00, 8'h30, 8'he5, TUNE, 8'h70, 8'hf8, 8'hff, 8'hff};

  srb_special_register_bank #(.FACTORY_TUNE(TUNE)) i_dut (
    .core_clk(core_clk), .resetn(resetn), .access(access), .cause(cause),
    .flashStatus(flashStatus), .rdata(rdata), .rdValid(rdValid),
    .flashCommand(flashCommand), .flashCommandStrobe(flashCommandStrobe),
    .baudWriteHazard(baudWriteHazard), .machineCycleEnable(machineCycleEnable),
    .peripheralClockEnable(peripheralClockEnable), .port0ModeA(port0ModeA),
    .port1ModeA(port1ModeA), .port3ModeA(port3ModeA),
    .watchdogControl(watchdogControl), .rcTune(rcTune), .baudControl(baudControl)
  );

  // free-running cpu clock
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  // compare and count; case inequality so unknowns fail
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
    checksDone++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  // one access held across one edge; entered just after an edge
  task automatic acc(input logic r, input logic w, input logic b, input logic ind,
      input logic [7:0] a, input logic [7:0] d);
    access = '{rd: r, wr: w, bitOp: b, indirect: ind, addr: a, wdata: d};
    @(posedge core_clk);
    #1;
  endtask

  // bus idle for one cycle
  task automatic idle();
    access = '0;
    @(posedge core_clk);
    #1;
  endtask

  // direct read, answer is due just after the edge that takes the read
  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input logic [7:0] m = 8'hff);
    acc(1'b1, 1'b0, 1'b0, 1'b0, a, 8'h00);
    chk({7'h00, rdValid}, 8'h01, "read answer");
    chk(rdata & m, exp, "read data");
    idle();
  endtask

  // direct write; pulses are captured before they drop
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic b = 1'b0);
    acc(1'b0, 1'b1, b, 1'b0, a, d);
    lastStrobe = flashCommandStrobe;
    lastHazard = baudWriteHazard;
    idle();
  endtask

  // let go of reset; cause stays put through the load edge
  task automatic releaseReset();
    repeat (6) @(posedge core_clk);
    #1;
    resetn = 1'b1;
    repeat (2) @(posedge core_clk);
    #1;
  endtask

  // reset with a given source
  task automatic doReset(input srb_reset_cause_t c);
    resetn = 1'b0;
    cause = c;
    releaseReset();
  endtask

  // full power-on image, through reads and the mode outputs
  task automatic checkPor();
    for (int i = 0; i < 17; i++) begin // defined locations only
      rd(porAddr[i], porVal[i]);
    end
    chk(port0ModeA, 8'hff, "port0 mode");
    chk(port1ModeA, 8'hd3, "port1 mode");
    chk(port3ModeA, 8'h03, "port3 mode");
    chk(watchdogControl, 8'he5, "watchdog control");
    chk(rcTune, TUNE & MASK_RC_TUNE, "tune output");
  endtask

  // verdict, reached from the main sequence or the watchdog
  task automatic summarize();
    $display("checks %0d mismatches %0d", checksDone, fails);
    if (fails == 0 && checksDone > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // hang guard, about five times the expected run
  initial begin
    #100000;
    fails++;
    $display("MISMATCH t=%0t timeout", $time);
    summarize();
  end

  // main sequence
  initial begin
    access = '0;
    flashStatus = 8'h00;
    resetn = 1'b0;
    cause = 6'h30; // power-up with brownout flag
    releaseReset();
    checkPor();
    $display("test power_on_image done");
    // fixed-zero and reserved bits read zero whatever is written
    wr(8'ha2, 8'hff);
    rd(8'ha2, 8'hf9);
    wr(8'hbd, 8'hfc);
    rd(8'hbd, 8'h00);
    wr(8'hd9, 8'h00);
    rd(8'hd9, 8'hf8);
    // write then read on the very next edge
    acc(1'b0, 1'b1, 1'b0, 1'b0, 8'h95, 8'h3c);
    rd(8'h95, 8'h3c);
    $display("test fixed_bits done");
    // flash location: writes are commands, reads are status
    wr(8'he4, 8'h5a);
    chk({7'h00, lastStrobe}, 8'h01, "flash strobe");
    chk(flashCommand, 8'h5a, "flash command");
    flashStatus = 8'h8f;
    rd(8'he4, 8'hff);
    flashStatus = 8'h00;
    rd(8'he4, 8'h70);
    $display("test flash_location done");
    // single-bit writes on a bit-addressable register, byte write elsewhere
    wr(8'h88, 8'h00);
    wr(8'h88, 8'h0d, 1'b1);
    wr(8'h88, 8'h08, 1'b1);
    rd(8'h88, 8'h21);
    wr(8'h88, 8'h05, 1'b1);
    rd(8'h88, 8'h01);
    wr(8'h89, 8'h0d, 1'b1);
    rd(8'h89, 8'h0d);
    $display("test bit_access done");
    // indirect and low addresses never reach the bank
    wr(8'h81, 8'h55);
    acc(1'b0, 1'b1, 1'b0, 1'b1, 8'h81, 8'haa);
    acc(1'b1, 1'b0, 1'b0, 1'b1, 8'h81, 8'h00);
    chk({7'h00, rdValid}, 8'h00, "indirect answer");
    acc(1'b1, 1'b0, 1'b0, 1'b0, 8'h7f, 8'h00);
    chk({7'h00, rdValid}, 8'h00, "low address answer");
    idle();
    rd(8'h81, 8'h55);
    $display("test direct_only done");
    // divisor write flagged only while the generator runs
    wr(8'hbd, 8'h00); // generator off before divisor writes
    wr(8'hbe, 8'h12);
    chk({7'h00, lastHazard}, 8'h00, "divisor write idle");
    wr(8'hbd, 8'h01);
    chk(baudControl, 8'h01, "baud control");
    wr(8'hbf, 8'h34);
    chk({7'h00, lastHazard}, 8'h01, "divisor write running");
    wr(8'hbd, 8'h00);
    $display("test baud_guard done");
    // both enables alternate every cpu clock
    for (int i = 0; i < 4; i++) begin
      pm = machineCycleEnable;
      pp = peripheralClockEnable;
      @(posedge core_clk);
      #1;
      chk({6'h00, machineCycleEnable, peripheralClockEnable}, {6'h00, ~pm, ~pp}, "enables");
    end
    $display("test clock_enables done");
    // warm resets keep the power-on-only registers
    wr(8'ha7, 8'h00); // reserved bits written zero
    wr(8'hd1, 8'h01);
    wr(8'hd2, 8'h12);
    wr(8'h96, 8'h05);
    wr(8'h84, 8'h00);
    doReset(6'h08); // watchdog reset
    rd(8'ha7, 8'h02);
    rd(8'hd1, 8'h01);
    rd(8'hd2, 8'h12);
    rd(8'h96, 8'h05);
    rd(8'h84, 8'hff);
    rd(8'hdf, 8'h04, 8'h04);
    doReset(6'h02); // external reset
    rd(8'ha7, 8'h02);
    rd(8'hdf, 8'h01, 8'h01);
    doReset(6'h04); // software reset
    rd(8'hdf, 8'h02, 8'h02);
    doReset(6'h01); // break-detect reset
    rd(8'hdf, 8'h08, 8'h08);
    rd(8'ha7, 8'h02);
    doReset(6'h10); // brownout alone, no power-on flag
    rd(8'hdf, 8'h20, 8'h30);
    rd(8'hd1, 8'h01);
    doReset(6'h30); // power-up again restores everything
    checkPor();
    $display("test warm_resets done");
    summarize();
  end
endmodule
